// File: bench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic i_clk,
  output synth_port_pkg::serial_pins_t o_pins,
  output logic o_done
);
  import synth_port_pkg::*;
  initial begin
    o_pins = 3'b001;
    o_done = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Select only moves with the clock low
  task automatic send(input int n, input logic [31:0] v);
    o_pins.select_n = 1'b0;
    for (int b = n - 1; b >= 0; b--) begin
      o_pins.data = v[b];
      tick(2);
      o_pins.sclk = 1'b1;
      tick(2);
      o_pins.sclk = 1'b0;
    end
    tick(2);
    o_pins.select_n = 1'b1;
    o_pins.data = ~o_pins.data; // Released line shows no stale bit
    tick(6);
    o_done = 1'b1;
    tick(1);
    o_done = 1'b0;
  endtask
endmodule // host_model

// File: bench/synth_port_props.sv
`timescale 1ns/1ps
module synth_port_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire synth_port_pkg::serial_pins_t i_pins,
  input wire logic o_multi_out,
  input wire logic o_open_drain_out,
  input wire logic o_open_drain_oe_n,
  input wire logic [7:0] o_config,
  input wire logic [15:0] o_ref_word,
  input wire logic [12:0] o_ref_active,
  input wire logic [23:0] o_counter_word
);
  import synth_port_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Registers frozen while bits shift in
  property p_cfg; !i_pins.select_n [*5] |-> $stable(o_config); endproperty
  a_cfg: assert property (p_cfg) else $error("config moved");
  property p_ref; !i_pins.select_n [*5] |-> $stable(o_ref_word); endproperty
  a_ref: assert property (p_ref) else $error("ratio moved");
  property p_cnt; !i_pins.select_n [*5] |->
    $stable(o_counter_word) && $stable(o_ref_active); endproperty
  a_cnt: assert property (p_cnt) else $error("counter moved");
  property p_od; o_open_drain_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("drain high");
  // Lag tolerated: both outputs are registered views
  property p_oe; $stable(o_config) [*3] |->
    o_open_drain_oe_n == o_config[0]; endproperty
  a_oe: assert property (p_oe) else $error("oe_n wrong");
  property p_port; ($stable(o_config) && $stable(o_counter_word)) [*3]
    ##0 (o_counter_word[23:22] == 2'b00) |->
    o_multi_out == o_config[1]; endproperty
  a_port: assert property (p_port) else $error("port bit");
  // Reset checks must run while reset is high
  property p_rod; disable iff (1'b0) i_rst |=> !o_open_drain_oe_n;
  endproperty
  a_rod: assert property (p_rod) else $error("oe_n reset");
  property p_rsel; disable iff (1'b0) i_rst |=>
    o_counter_word[23:22] == 2'b01; endproperty
  a_rsel: assert property (p_rsel) else $error("mode reset");
endmodule // synth_port_props
bind synth_serial_program_port synth_port_props props_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_pins(i_pins),
  .o_multi_out(o_multi_out), .o_open_drain_out(o_open_drain_out),
  .o_open_drain_oe_n(o_open_drain_oe_n), .o_config(o_config),
  .o_ref_word(o_ref_word), .o_ref_active(o_ref_active),
  .o_counter_word(o_counter_word));

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import synth_port_pkg::*;
  logic i_clk, i_rst, i_ref_in, i_rf_in, o_multi_out, done, ovf;
  logic o_open_drain_out, o_open_drain_oe_n;
  serial_pins_t pins;
  logic [7:0] o_config, cfg;
  logic [15:0] o_ref_word, rw;
  logic [12:0] o_ref_active, act;
  logic [23:0] o_counter_word, cnt;
  logic [61:0] got;
  logic [61:0] expq[$];
  logic [15:0] lfsr = 16'hED31;
  logic [31:0] v;
  int fails = 0, n_tests = 0, cycles = 0;
  int lens[8] = '{8, 16, 24, 0, 12, 32, 9, 24};
  synth_serial_program_port synth_serial_program_port_i (.i_clk(i_clk),
    .i_rst(i_rst), .i_pins(pins), .i_ref_in(i_ref_in), .i_rf_in(i_rf_in),
    .o_multi_out(o_multi_out), .o_open_drain_out(o_open_drain_out),
    .o_open_drain_oe_n(o_open_drain_oe_n), .o_config(o_config),
    .o_ref_word(o_ref_word), .o_ref_active(o_ref_active),
    .o_counter_word(o_counter_word), .o_xfer_overflow(ovf));
  host_model host_model_i (.i_clk(i_clk), .o_pins(pins), .o_done(done));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic summarize();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Single-bit pin check against a rule-derived level
  task automatic check(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Note the expected view, then hand the frame to the host
  task automatic xfer(input int n, input logic [31:0] d);
    case (n)
      8: cfg = d[7:0];
      16: rw = d[15:0];
      24: begin
        cnt = d[23:0];
        act = rw[12:0];
      end
      0: act = rw[12:0];
      default: ;
    endcase
    expq.push_back({1'b0, cfg, rw, act, cnt});
    host_model_i.send(n, d);
  endtask
  initial begin
    i_rst = 1'b1;
    i_ref_in = 1'b0;
    i_rf_in = 1'b0;
    {cfg, rw, act, cnt} = {8'h00, 16'h0000, 13'h0000, 24'h40_0000};
    repeat (10) @(posedge i_clk);
    #1 i_rst = 1'b0;
    check(o_open_drain_oe_n, 1'b0);
    xfer(12, 32'h0000_0FFF);
    for (int k = 0; k < 40; k++) begin
      lfsr = step(step(lfsr));
      v = {step(lfsr), lfsr};
      v[17] = 1'b1;
      i_ref_in = v[3];
      i_rf_in = v[9];
      xfer(lens[lfsr[2:0]], v);
    end
    xfer(8, 32'h0000_0003);
    check(o_open_drain_oe_n, 1'b1);
    xfer(24, 32'h0002_0000);
    check(o_multi_out, 1'b1);
    summarize();
  end
  // Compare the oldest note whenever the host reports a result
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
    if (done) begin
      got = {ovf, o_config, o_ref_word, o_ref_active, o_counter_word};
      n_tests++;
      if (got !== expq[0]) begin
        fails++;
        $display("[FAIL] %0t got %h exp %h", $time, got, expq[0]);
      end
      void'(expq.pop_front());
    end
  end
endmodule // testbench

// File: rtl/synth_port_map.svh
`ifndef SYNTH_PORT_MAP_SVH
`define SYNTH_PORT_MAP_SVH

// Transfer lengths: 8, 16 and 24 select a destination register, 32 selects none
`define LEN_CONFIG 6'd8
`define LEN_REFDIV 6'd16
`define LEN_COUNTER 6'd24
`define LEN_MAX 6'd32

// Field positions and prescaler modulus
`define REF_RATIO_MSB 12
`define REF_MODE_LSB 13
`define SEL_HIGH_BIT 23
`define SEL_LOW_BIT 22
`define MAIN_MSB 17
`define MAIN_LSB 6
`define SWALLOW_MSB 5
`define PORT_BIT 1
`define OUTB_BIT 0
`define PRESCALE 14'd64

// Reset values
`define CONFIG_RST 8'h00
`define REFDIV_RST 16'h0000
`define COUNTER_RST 24'h40_0000

// Staging FIFO shape
`define FIFO_WIDTH 32
`define FIFO_DEPTH 16

`endif

// File: rtl/synth_port_pkg.sv
package synth_port_pkg;
  typedef enum logic [1:0] {
    SEL_PORT,
    SEL_CASCADE,
    SEL_VCO,
    SEL_REF
  } out_sel_t;

  // One completed transfer: length and bits
  typedef struct packed {
    logic [5:0] len;
    logic [25:0] bits;
  } xfer_t;

  // Serial pins as seen by the port
  typedef struct packed {
    logic data;
    logic sclk;
    logic select_n;
  } serial_pins_t;
endpackage

// File: rtl/synth_serial_program_port.sv
// Overview of operation
// - MSB first, sampled on shift clock rise
// - 8, 16, 24 clocks pick the register
// - Registers load only one clock after select rising, as the FIFO drains
// - Ratio double-buffered, mode bits load immediately
// - Counter load commits second ratio buffer
// - Empty select pulse also commits ratio buffer
// - No address bits, any register order
// - Half-stage shifter drives data out falling
// - Select high holds port initialized
// - Resync once select high, clock low
// - Counter bits 23:22 choose output mode
// - Reference pulse from 13-bit ratio divider
// - VCO pulse divides by main*64+swallow
// - Output powers up in cascade mode
// - Port mode outputs configuration bit 1
// - Open-drain output follows configuration bit 0
// - Reset drives open-drain output low
`timescale 1ns/1ps
`include "synth_port_map.svh"
module synth_serial_program_port (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire synth_port_pkg::serial_pins_t i_pins,
  input wire logic i_ref_in,
  input wire logic i_rf_in,
  output logic o_multi_out,
  output logic o_open_drain_out,
  output logic o_open_drain_oe_n,
  output logic [7:0] o_config,
  output logic [15:0] o_ref_word,
  output logic [12:0] o_ref_active,
  output logic [23:0] o_counter_word,
  output logic o_xfer_overflow
);
  import synth_port_pkg::*;

  logic sclk_d_ff;
  logic sel_d_ff;
  logic sync_ok_ff;
  logic [25:0] shift_ff;
  logic [5:0] count_ff;
  logic cascade_ff;
  logic [7:0] config_ff;
  logic [15:0] ref_buf_ff;
  logic [12:0] ref_act_ff;
  logic [23:0] counter_ff;
  logic [12:0] ref_cnt_ff;
  logic ref_pulse_ff;
  logic [6:0] pre_cnt_ff;
  logic pre_mod;
  logic [11:0] main_cnt_ff;
  logic [5:0] swal_cnt_ff;
  logic vco_pulse_ff;
  logic multi_ff;
  logic od_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_rise;
  logic sel_fall;
  logic fifo_in_ready;
  logic fifo_valid;
  xfer_t fifo_word;
  xfer_t nxt_word;
  logic [11:0] main_val;
  logic [5:0] swal_val;
  out_sel_t mode_sel;

  // Edge detection on already-synchronous pins
  assign sclk_rise = i_pins.sclk && !sclk_d_ff;
  assign sclk_fall = !i_pins.sclk && sclk_d_ff;
  assign sel_rise = i_pins.select_n && !sel_d_ff;
  assign sel_fall = !i_pins.select_n && sel_d_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sclk_d_ff <= 1'b0;
      sel_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= i_pins.sclk;
      sel_d_ff <= i_pins.select_n;
    end
  end

  // Select moved while clock high breaks framing until both idle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_ok_ff <= 1'b1;
    end else if ((sel_rise || sel_fall) && i_pins.sclk) begin
      sync_ok_ff <= 1'b0;
    end else if (i_pins.select_n && !i_pins.sclk) begin
      sync_ok_ff <= 1'b1;
    end
  end

  // Shift register: count saturates at 63, so counts stay valid through 63 clocks, not beyond
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shift_ff <= '0;
      count_ff <= '0;
    end else if (i_pins.select_n) begin
      count_ff <= '0;
    end else if (sclk_rise && sync_ok_ff) begin
      shift_ff <= {shift_ff[24:0], i_pins.data};
      if (count_ff != 6'h3F) begin
        count_ff <= count_ff + 6'd1;
      end
    end
  end

  // Half stage: last bit re-timed to the falling shift clock
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cascade_ff <= 1'b0;
    end else if (sclk_fall && !i_pins.select_n) begin
      cascade_ff <= shift_ff[23];
    end
  end

  // Completed transfers queue here; lost only if 16 back up
  assign nxt_word.len = count_ff;
  assign nxt_word.bits = shift_ff;

  xfer_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(sel_rise && sync_ok_ff),
    .o_in_ready(fifo_in_ready),
    .i_in_data(nxt_word),
    .o_out_valid(fifo_valid),
    .i_out_ready(1'b1),
    .o_out_data(fifo_word)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_xfer_overflow <= 1'b0;
    end else if (sel_rise && sync_ok_ff && !fifo_in_ready) begin
      o_xfer_overflow <= 1'b1;
    end
  end

  // Register loads happen only as a transfer is drained
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      config_ff <= `CONFIG_RST;
      ref_buf_ff <= `REFDIV_RST;
      ref_act_ff <= 13'h0000;
      counter_ff <= `COUNTER_RST;
    end else if (fifo_valid) begin
      if (fifo_word.len == `LEN_CONFIG) begin
        config_ff <= fifo_word.bits[7:0];
      end else if (fifo_word.len == `LEN_REFDIV) begin
        ref_buf_ff <= fifo_word.bits[15:0];
      end else if (fifo_word.len == `LEN_COUNTER) begin
        counter_ff <= fifo_word.bits[23:0];
        ref_act_ff <= ref_buf_ff[`REF_RATIO_MSB:0];
      end else if (fifo_word.len == 6'd0) begin
        ref_act_ff <= ref_buf_ff[`REF_RATIO_MSB:0];
      end
      // Any other length loads nothing
    end
  end

  // Reference divider, 13 stages; ratio 1 passes input through
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ref_cnt_ff <= '0;
      ref_pulse_ff <= 1'b0;
    end else if (ref_act_ff == 13'h0001) begin
      ref_pulse_ff <= i_ref_in;
    end else if (i_ref_in) begin
      if (ref_cnt_ff + 13'd1 >= ref_act_ff) begin
        ref_cnt_ff <= '0;
        ref_pulse_ff <= 1'b1;
      end else begin
        ref_cnt_ff <= ref_cnt_ff + 13'd1;
        ref_pulse_ff <= 1'b0;
      end
    end else begin
      ref_pulse_ff <= 1'b0;
    end
  end

  // Dual-modulus chain: 65 for swallow cycles, then 64
  assign main_val = counter_ff[`MAIN_MSB:`MAIN_LSB];
  assign swal_val = counter_ff[`SWALLOW_MSB:0];
  assign pre_mod = (swal_cnt_ff != swal_val);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pre_cnt_ff <= '0;
      main_cnt_ff <= '0;
      swal_cnt_ff <= '0;
      vco_pulse_ff <= 1'b0;
    end else begin
      vco_pulse_ff <= 1'b0;
      if (i_rf_in) begin
        // Extra count while swallowing gives main*64+swallow
        // Host must keep main >= swallow or swallowing never ends
        if (pre_cnt_ff >= (pre_mod ? 7'd64 : 7'd63)) begin
          pre_cnt_ff <= '0;
          if (pre_mod) begin
            swal_cnt_ff <= swal_cnt_ff + 6'd1;
          end
          if (main_cnt_ff + 12'd1 >= main_val) begin
            main_cnt_ff <= '0;
            swal_cnt_ff <= '0;
            vco_pulse_ff <= 1'b1;
          end else begin
            main_cnt_ff <= main_cnt_ff + 12'd1;
          end
        end else begin
          pre_cnt_ff <= pre_cnt_ff + 7'd1;
        end
      end
    end
  end

  // Output mode select and registered pins
  assign mode_sel = out_sel_t'({counter_ff[`SEL_HIGH_BIT],
                                counter_ff[`SEL_LOW_BIT]});

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      multi_ff <= 1'b0;
      od_ff <= 1'b0;
    end else begin
      case (mode_sel)
        SEL_REF: begin
          multi_ff <= ref_pulse_ff;
        end
        SEL_VCO: begin
          multi_ff <= vco_pulse_ff;
        end
        SEL_CASCADE: begin
          multi_ff <= cascade_ff;
        end
        default: begin
          multi_ff <= config_ff[`PORT_BIT];
        end
      endcase
      od_ff <= config_ff[`OUTB_BIT];
    end
  end

  assign o_multi_out = multi_ff;
  assign o_open_drain_out = 1'b0;
  assign o_open_drain_oe_n = od_ff;
  assign o_config = config_ff;
  assign o_ref_word = {ref_buf_ff[15:`REF_MODE_LSB], 13'h0000} |
                      {3'h0, ref_buf_ff[`REF_RATIO_MSB:0]};
  assign o_ref_active = ref_act_ff;
  assign o_counter_word = counter_ff;
endmodule // synth_serial_program_port

// File: rtl/xfer_fifo.sv
`timescale 1ns/1ps
module xfer_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  // Honest flags from the fill count
  assign o_in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rd_ff];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Storage written by index
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + AW'(1);
      end
      if (pop) begin
        rd_ff <= rd_ff + AW'(1);
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // xfer_fifo
